// ==== hdl/pv_inverter_pwm_control.sv ====
`timescale 1ns/1ns
// Overview of operation
// - Flyback driven by main and clamp gates
// - Flyback uses panel voltage, current, bus
// - MPPT sets panel reference current
// - Current error into 2P2Z gives duty
// - Bus over-voltage watched every cycle
// - 12-bit samples; loops run each tick
// - Active leg upper switch held on
// - Active leg lower switch PWM at 50kHz
// - Four inverter gates: low A/B, high A/B
// - Relay connects mains when asserted
// - Inverter uses line, bus, inductor current
// - Bus 2P2Z loop yields current reference
// - Inductor current tracked by 3P3Z
// - PLL locks current reference to grid
// - Lower duty by feedback linearization
// - Linearization uses measured bus, line voltage
// - PLL filter A1, B0, B1 per tick
module pv_inverter_pwm_control (
  // Clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      rstn,
  // Sampled feedback
  input  wire logic [pvi_pkg::ADC_W-1:0] panel_voltage,
  input  wire logic [pvi_pkg::ADC_W-1:0] panel_current,
  input  wire logic [pvi_pkg::ADC_W-1:0] bus_voltage,
  input  wire logic [pvi_pkg::ADC_W-1:0] line_voltage,
  input  wire logic [pvi_pkg::ADC_W-1:0] inductor_current,
  // Control
  input  wire logic                      relay_enable,
  input  wire logic                      fault_clear,
  // Gates and status
  output logic                           flyback_main_gate,
  output logic                           flyback_clamp_gate,
  output logic                           inv_pos_low_gate,
  output logic                           inv_neg_low_gate,
  output logic                           inv_pos_high_gate,
  output logic                           inv_neg_high_gate,
  output logic                           grid_relay,
  output logic                           over_voltage
);
  import pvi_pkg::*;

  function automatic int sat(input int x, input int hi);
    sat = (x < 0) ? 0 : ((x > hi) ? hi : x);
  endfunction : sat

  function automatic int mag(input int x);
    mag = (x < 0) ? -x : x;
  endfunction : mag

  logic [CNT_W-1:0] pwm_cnt_ff;
  logic [31:0]      phase_ff;
  logic             line_pos_ff;
  int               mppt_cnt_ff, mppt_ref_ff, p_prev_ff;
  logic             mppt_up_ff;
  int               fb_u1_ff, fb_u2_ff, fb_e1_ff, fb_e2_ff, fb_cmp_ff;
  int               bv_u1_ff, bv_u2_ff, bv_e1_ff, bv_e2_ff;
  int               ic_u1_ff, ic_u2_ff, ic_u3_ff, ic_e1_ff, ic_e2_ff, ic_e3_ff, inv_cmp_ff;
  int               ylf1_ff, vq1_ff;

  wire tick = (pwm_cnt_ff == CNT_W'(PWM_PERIOD - 1));
  // Samples as signed integers; bipolar channels are offset around mid scale
  // Nets need a four-state type, so the signed arithmetic runs on integer nets
  wire integer vpv_i  = int'(panel_voltage);
  wire integer ipv_i  = int'(panel_current);
  wire integer vbus_i = int'(bus_voltage);
  wire integer vln_i  = int'(line_voltage) - ADC_MID;
  wire integer il_i   = int'(inductor_current) - ADC_MID;
  wire ov_now     = (vbus_i > OV_THRESH);

  // Perturb and observe on panel power
  wire integer p_now = vpv_i * ipv_i;
  wire      mppt_go = tick && (mppt_cnt_ff == MPPT_TICKS - 1);
  wire      nxt_up  = (p_now < p_prev_ff) ? !mppt_up_ff : mppt_up_ff;
  wire integer nxt_mppt_ref = sat(mppt_ref_ff + (nxt_up ? MPPT_STEP : -MPPT_STEP), IREF_MAX);

  wire integer fb_err = mppt_ref_ff - ipv_i;
  wire integer fb_u   = sat((FB_A1 * fb_u1_ff + FB_A2 * fb_u2_ff + FB_B0 * fb_err
                        + FB_B1 * fb_e1_ff + FB_B2 * fb_e2_ff) >>> Q_SHIFT, DUTY_MAX);

  // Bus above reference means more current must go to the grid
  wire integer bv_err = vbus_i - VBUS_REF;
  wire integer bv_u   = sat((BV_A1 * bv_u1_ff + BV_A2 * bv_u2_ff + BV_B0 * bv_err
                        + BV_B1 * bv_e1_ff + BV_B2 * bv_e2_ff) >>> Q_SHIFT, IREF_MAX);

  // Phase detector: line voltage against the sign of cos(theta)
  wire     cos_pos = (phase_ff[31] == phase_ff[30]);
  wire integer vq  = cos_pos ? vln_i : -vln_i;
  wire integer ylf = (PLL_A1 * ylf1_ff + PLL_B0 * vq + PLL_B1 * vq1_ff) >>> Q_SHIFT;
  // Triangle approximation of |sin(theta)| keeps the shaping table-free
  wire [FOLD_HI-FOLD_LO:0] fold = phase_ff[30] ? ~phase_ff[FOLD_HI:FOLD_LO] : phase_ff[FOLD_HI:FOLD_LO];
  wire integer inductor_current_ref = (bv_u1_ff * int'(fold)) >>> Q_SHIFT;

  wire integer ic_err = inductor_current_ref - mag(il_i);
  wire integer ic_u   = sat((IC_A1 * ic_u1_ff + IC_A2 * ic_u2_ff + IC_A3 * ic_u3_ff + IC_B0 * ic_err
                        + IC_B1 * ic_e1_ff + IC_B2 * ic_e2_ff + IC_B3 * ic_e3_ff) >>> Q_SHIFT, DUTY_MAX);
  // Duty = (Ui + |Vline|) / Vbus scaled to the period; bus floor avoids a divide by zero
  wire integer vbus_den = (vbus_i < 1) ? 1 : vbus_i;
  wire integer inv_duty = sat(((ic_u + mag(vln_i)) * PWM_PERIOD) / vbus_den, DUTY_MAX);

  wire nxt_main     = !over_voltage && (int'(pwm_cnt_ff) < fb_cmp_ff);
  wire nxt_clamp    = !over_voltage && !nxt_main;
  wire inv_on       = !over_voltage && (int'(pwm_cnt_ff) < inv_cmp_ff);
  wire nxt_ov       = ov_now || (over_voltage && !fault_clear);

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pwm_cnt_ff <= '0;
      over_voltage <= 1'b0;
    end
    else
    begin
      pwm_cnt_ff <= tick ? '0 : pwm_cnt_ff + 1'b1;
      over_voltage <= nxt_ov;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      // First perturbation at the first tick, so the flyback loop is not idle for a whole interval
      mppt_cnt_ff <= MPPT_TICKS - 1;
      mppt_ref_ff <= 0;
      p_prev_ff <= 0;
      mppt_up_ff <= 1'b1;
    end
    else if (tick)
    begin
      mppt_cnt_ff <= mppt_go ? 0 : mppt_cnt_ff + 1;
      if (mppt_go)
      begin
        mppt_up_ff <= nxt_up;
        mppt_ref_ff <= nxt_mppt_ref;
        p_prev_ff <= p_now;
      end
    end
  end

  // Loop states advance once per tick; compare values load at the period boundary
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      {fb_u1_ff, fb_u2_ff, fb_e1_ff, fb_e2_ff, fb_cmp_ff} <= '0;
      {bv_u1_ff, bv_u2_ff, bv_e1_ff, bv_e2_ff} <= '0;
      {ic_u1_ff, ic_u2_ff, ic_u3_ff, ic_e1_ff, ic_e2_ff, ic_e3_ff, inv_cmp_ff} <= '0;
      {ylf1_ff, vq1_ff} <= '0;
      phase_ff <= '0;
      line_pos_ff <= 1'b1;
    end
    else if (tick)
    begin
      {fb_u2_ff, fb_u1_ff, fb_e2_ff, fb_e1_ff} <= {fb_u1_ff, fb_u, fb_e1_ff, fb_err};
      fb_cmp_ff <= fb_u;
      {bv_u2_ff, bv_u1_ff, bv_e2_ff, bv_e1_ff} <= {bv_u1_ff, bv_u, bv_e1_ff, bv_err};
      {ic_u3_ff, ic_u2_ff, ic_u1_ff} <= {ic_u2_ff, ic_u1_ff, ic_u};
      {ic_e3_ff, ic_e2_ff, ic_e1_ff} <= {ic_e2_ff, ic_e1_ff, ic_err};
      inv_cmp_ff <= inv_duty;
      {ylf1_ff, vq1_ff} <= {ylf, vq};
      phase_ff <= phase_ff + PLL_NOM + 32'(ylf);
      line_pos_ff <= (vln_i >= 0);
    end
  end

  // No dead time between main and clamp: the gate drivers must provide it
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      {flyback_main_gate, flyback_clamp_gate} <= 2'h0;
      {inv_pos_low_gate, inv_neg_low_gate, inv_pos_high_gate, inv_neg_high_gate} <= 4'h0;
      grid_relay <= 1'b0;
    end
    else
    begin
      flyback_main_gate <= nxt_main;
      flyback_clamp_gate <= nxt_clamp;
      inv_pos_low_gate <= inv_on && line_pos_ff;
      inv_neg_low_gate <= inv_on && !line_pos_ff;
      inv_pos_high_gate <= !over_voltage && line_pos_ff;
      inv_neg_high_gate <= !over_voltage && !line_pos_ff;
      grid_relay <= relay_enable && !nxt_ov;
    end
  end

  property p_fly_excl;
    @(posedge ref_clk) disable iff (!rstn)
    !(flyback_main_gate && flyback_clamp_gate);
  endproperty
  a_fly_excl: assert property (p_fly_excl) else $error("flyback gates both on");

  property p_ov_set;
    @(posedge ref_clk) disable iff (!rstn)
    ov_now |=> over_voltage;
  endproperty
  a_ov_set: assert property (p_ov_set) else $error("over-voltage not latched");

  property p_ov_shut;
    @(posedge ref_clk) disable iff (!rstn)
    over_voltage |=> !flyback_main_gate && !flyback_clamp_gate && !inv_pos_low_gate && !inv_neg_low_gate
                     && !inv_pos_high_gate && !inv_neg_high_gate;
  endproperty
  a_ov_shut: assert property (p_ov_shut) else $error("gates active during over-voltage");

  property p_ov_hold;
    @(posedge ref_clk) disable iff (!rstn)
    over_voltage && !fault_clear |=> over_voltage;
  endproperty
  a_ov_hold: assert property (p_ov_hold) else $error("over-voltage dropped without clear");

  property p_relay;
    @(posedge ref_clk) disable iff (!rstn)
    grid_relay |-> $past(relay_enable) && !over_voltage;
  endproperty
  a_relay: assert property (p_relay) else $error("relay closed without enable");

  property p_leg_excl;
    @(posedge ref_clk) disable iff (!rstn)
    !(inv_pos_high_gate && inv_neg_high_gate) && !(inv_pos_low_gate && inv_neg_low_gate);
  endproperty
  a_leg_excl: assert property (p_leg_excl) else $error("both legs active");

  property p_low_in_half;
    @(posedge ref_clk) disable iff (!rstn)
    (inv_pos_low_gate |-> inv_pos_high_gate) and (inv_neg_low_gate |-> inv_neg_high_gate);
  endproperty
  a_low_in_half: assert property (p_low_in_half) else $error("lower switch outside its half cycle");

  property p_tick;
    @(posedge ref_clk) disable iff (!rstn)
    tick |=> pwm_cnt_ff == '0 ##1 (pwm_cnt_ff == CNT_W'(1));
  endproperty
  a_tick: assert property (p_tick) else $error("pwm period wrap wrong");

  property p_duty_sat;
    @(posedge ref_clk) disable iff (!rstn)
    fb_cmp_ff >= 0 && fb_cmp_ff <= DUTY_MAX && inv_cmp_ff >= 0 && inv_cmp_ff <= DUTY_MAX;
  endproperty
  a_duty_sat: assert property (p_duty_sat) else $error("duty out of range");

  property p_main_duty;
    @(posedge ref_clk) disable iff (!rstn)
    !over_voltage && !ov_now && (int'(pwm_cnt_ff) < fb_cmp_ff) |=> flyback_main_gate;
  endproperty
  a_main_duty: assert property (p_main_duty) else $error("main gate missed its duty");
endmodule : pv_inverter_pwm_control

// ==== hdl/pvi_pkg.sv ====
package pvi_pkg;
  localparam int          CLK_HZ      = 125_000_000;
  localparam int          PWM_HZ      = 50_000;
  localparam int          PWM_PERIOD  = CLK_HZ / PWM_HZ;
  localparam int          CNT_W       = 12;
  localparam int          ADC_W       = 12;
  localparam int          ADC_MID     = 2048;
  localparam int          Q_SHIFT     = 12;
  localparam int          DUTY_MAX    = (PWM_PERIOD * 9) / 10;
  localparam int          OV_THRESH   = 3900;
  localparam int          VBUS_REF    = 3400;
  localparam int          IREF_MAX    = 2047;
  localparam int          MPPT_TICKS  = 500;
  localparam int          MPPT_STEP   = 8;
  // Flyback 2P2Z, Q12
  localparam int          FB_A1 = 4096;
  localparam int          FB_A2 = 0;
  localparam int          FB_B0 = 820;
  localparam int          FB_B1 = -700;
  localparam int          FB_B2 = 0;
  // Bus voltage 2P2Z, Q12
  localparam int          BV_A1 = 4096;
  localparam int          BV_A2 = 0;
  localparam int          BV_B0 = 410;
  localparam int          BV_B1 = -380;
  localparam int          BV_B2 = 0;
  // Inductor current 3P3Z, Q12
  localparam int          IC_A1 = 6488;
  localparam int          IC_A2 = -2858;
  localparam int          IC_A3 = 466;
  localparam int          IC_B0 = 1174;
  localparam int          IC_B1 = -1300;
  localparam int          IC_B2 = 1384;
  localparam int          IC_B3 = -1071;
  // PLL loop filter, Q12
  localparam int          PLL_A1 = 4096;
  localparam int          PLL_B0 = 683;
  localparam int          PLL_B1 = -681;
  localparam logic [31:0] PLL_NOM = 32'h0041_8937;
  localparam int          FOLD_HI = 29;
  localparam int          FOLD_LO = 18;
endpackage : pvi_pkg

// ==== test/pv_stage_model.sv ====
`timescale 1ns/1ns
module pv_stage_model (
  // Clock
  input  wire logic        ref_clk,
  // Bench settings
  input  wire logic        line_pos,
  input  wire logic [11:0] bus_level,
  // Upper switch gates
  input  wire logic        pos_high,
  input  wire logic        neg_high,
  // Sensor samples
  output logic      [11:0] bus_voltage,
  output logic      [11:0] line_voltage,
  output logic      [11:0] inductor_current,
  // Bridge faults
  output int               shoots
);
  logic [9:0] ramp;
  initial
  begin
    ramp             = 10'h000;
    shoots           = 0;
    bus_voltage      = 12'h800;
    line_voltage     = 12'h800;
    inductor_current = 12'h800;
  end
  // Line and inductor samples move every cycle so a stuck read is not hidden; the bus sample follows bus_level
  always @(posedge ref_clk)
  begin
    ramp             <= ramp + 10'h001;
    bus_voltage      <= bus_level;
    line_voltage     <= line_pos ? 12'h800 + {2'h0, ramp} : 12'h7FF - {2'h0, ramp};
    inductor_current <= 12'h800 ^ {6'h00, ramp[5:0]};
    if (pos_high && neg_high)
      shoots <= shoots + 1;
  end
endmodule : pv_stage_model

// ==== test/testbench.sv ====
`timescale 1ns/1ns
module testbench;
  import pvi_pkg::*;
  logic       ref_clk, rstn, relay_enable, fault_clear, line_pos, ov_m, rel_m, quiet;
  logic [11:0] panel_voltage, panel_current, bus_voltage, line_voltage, inductor_current, bus_level;
  logic       flyback_main_gate, flyback_clamp_gate, inv_pos_low_gate, inv_neg_low_gate;
  logic       inv_pos_high_gate, inv_neg_high_gate, grid_relay, over_voltage;
  logic [2:0] g, g_q;
  int         n_errors = 0, checked = 0, seed = 32'h2070, cyc = 0, calm = 0, age = 0, shoots, fly_on = 0;
  int         last [3];
  pv_inverter_pwm_control dut (.ref_clk(ref_clk), .rstn(rstn), .panel_voltage(panel_voltage),
    .panel_current(panel_current), .bus_voltage(bus_voltage), .line_voltage(line_voltage),
    .inductor_current(inductor_current), .relay_enable(relay_enable), .fault_clear(fault_clear),
    .flyback_main_gate(flyback_main_gate), .flyback_clamp_gate(flyback_clamp_gate),
    .inv_pos_low_gate(inv_pos_low_gate), .inv_neg_low_gate(inv_neg_low_gate),
    .inv_pos_high_gate(inv_pos_high_gate), .inv_neg_high_gate(inv_neg_high_gate),
    .grid_relay(grid_relay), .over_voltage(over_voltage));
  pv_stage_model stage (.ref_clk(ref_clk), .line_pos(line_pos), .bus_level(bus_level),
    .pos_high(inv_pos_high_gate), .neg_high(inv_neg_high_gate), .bus_voltage(bus_voltage),
    .line_voltage(line_voltage), .inductor_current(inductor_current), .shoots(shoots));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop
  task automatic run(input int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      panel_voltage <= 12'($random(seed));
      panel_current <= quiet ? 12'h000 : 12'($random(seed));
      relay_enable  <= 1'($random(seed));
    end
  endtask : run
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Reference model of latch and relay, sampled with the design's edge
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ov_m  = 1'b0;
      rel_m = 1'b0;
      age   = 0;
      calm  = 0;
    end
    else
    begin
      if (bus_voltage > OV_THRESH)
        ov_m = 1'b1;
      else if (fault_clear)
        ov_m = 1'b0;
      rel_m = relay_enable & ~ov_m;
      age   = ov_m ? age + 1 : 0;
      calm  = ov_m ? 0 : calm + 1;
    end
  end
  always @(negedge ref_clk)
  begin
    g = {flyback_main_gate, inv_pos_low_gate, inv_neg_low_gate};
    if (rstn && flyback_main_gate)
      fly_on++;
    if (!rstn || age > 0)
      last = '{-1, -1, -1};
    if (!rstn)
      chk({flyback_main_gate, flyback_clamp_gate, g[1:0], inv_pos_high_gate, inv_neg_high_gate,
           grid_relay, over_voltage}, 0);
    else
    begin
      chk(over_voltage, ov_m);
      chk(grid_relay, rel_m);
      if (age >= 2)
        chk({g, flyback_clamp_gate, inv_pos_high_gate, inv_neg_high_gate}, 0);
      if (calm >= 2)
        chk(flyback_clamp_gate, !flyback_main_gate);
      for (int i = 0; i < 3; i++)
        if (g[i] && !g_q[i])
        begin
          if (last[i] >= 0)
            chk((cyc - last[i]) % PWM_PERIOD, 0);
          last[i] = cyc;
        end
    end
    g_q = g;
    cyc++;
  end
  initial
  begin
    rstn = 1'b0;
    fault_clear = 1'b0;
    line_pos = 1'b1;
    bus_level = 12'h800;
    panel_voltage = 12'h000;
    panel_current = 12'h000;
    relay_enable = 1'b0;
    quiet = 1'b1;
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    run(8000);
    @(negedge ref_clk);
    chk({inv_pos_high_gate, inv_neg_high_gate, inv_neg_low_gate}, 3'h4);
    chk(fly_on != 0, 1'b1);
    quiet <= 1'b0;
    $display("positive half done");
    line_pos <= 1'b0;
    run(8000);
    @(negedge ref_clk);
    chk({inv_pos_high_gate, inv_neg_high_gate, inv_pos_low_gate}, 3'h2);
    $display("negative half done");
    // Threshold itself must not trip; one above must, and clear loses to set
    bus_level <= 12'(OV_THRESH);
    run(20);
    bus_level <= 12'(OV_THRESH + 1);
    fault_clear <= 1'b1;
    run(10);
    bus_level <= 12'h800;
    fault_clear <= 1'b0;
    run(10);
    fault_clear <= 1'b1;
    run(1);
    fault_clear <= 1'b0;
    run(3000);
    $display("over-voltage latch done");
    bus_level <= 12'hFFF;
    run(5);
    rstn <= 1'b0;
    bus_level <= 12'h800;
    run(4);
    rstn <= 1'b1;
    run(3000);
    chk(over_voltage, 1'b0);
    chk(shoots, 0);
    $display("reset during fault done");
    report_and_stop();
  end
endmodule : testbench
